// ### tcc_pkg.sv
/*
 Package for the timer capture/compare unit: register byte offsets,
 field positions, reset values and output action codes.
 Assumes a 16-bit counter outside this block and an AXI4-Lite master.
*/
`default_nettype none
package tcc_pkg;
   localparam int          ADDR_W      = 8;
   localparam int          NUM_CH      = 3;
   localparam int          FILT_LEN    = 4;
   // Byte offsets, one 8-bit location per 32-bit word
   localparam logic [7:0]  OFS_CTRL    = 8'h00;
   localparam logic [7:0]  OFS_IRQ_EN  = 8'h04;
   localparam logic [7:0]  OFS_FLAGS   = 8'h08;
   localparam logic [7:0]  OFS_FORCE   = 8'h0C;
   localparam logic [7:0]  OFS_ACTION  = 8'h10;
   localparam logic [7:0]  OFS_CAP_LO  = 8'h14;
   localparam logic [7:0]  OFS_CAP_HI  = 8'h18;
   localparam logic [7:0]  OFS_CNT_LO  = 8'h1C;
   localparam logic [7:0]  OFS_CNT_HI  = 8'h20;
   localparam logic [7:0]  OFS_CMP_LO  = 8'h24;
   localparam logic [7:0]  OFS_CMP_HI  = 8'h28;
   localparam logic [7:0]  CMP_STRIDE  = 8'h08;
   localparam logic [7:0]  OFS_LAST    = 8'h38;
   // Control and flag field positions
   localparam int          CTRL_WGM    = 0;
   localparam int          CTRL_NF     = 4;
   localparam int          CTRL_RISE   = 5;
   localparam int          CTRL_COMPARATOR_CAPTURE_SELECT   = 6;
   localparam int          FLAG_CAP    = 0;
   localparam int          FLAG_CMP    = 1;
   localparam int          FLAG_OUT    = 4;
   // Reset values
   localparam logic [6:0]  CTRL_RST    = 7'h00;
   localparam logic [3:0]  IRQ_EN_RST  = 4'h0;
   localparam logic [5:0]  ACTION_RST  = 6'h00;
   localparam logic [15:0] WORD_RST    = 16'h0000;
   // Output actions on a match in non-PWM modes
   localparam logic [1:0]  ACT_NONE    = 2'h0;
   localparam logic [1:0]  ACT_TOGGLE  = 2'h1;
   localparam logic [1:0]  ACT_CLEAR   = 2'h2;
   // Fixed TOP values
   localparam logic [15:0] TOP_8BIT    = 16'h00FF;
   localparam logic [15:0] TOP_9BIT    = 16'h01FF;
   localparam logic [15:0] TOP_10BIT   = 16'h03FF;
   localparam logic [15:0] TOP_MAX     = 16'hFFFF;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ### tcc_capture_compare.sv
/*
 Capture/compare unit of a 16-bit timer with an AXI4-Lite register port.
 Assumes the counter, prescaler and pin muxing sit outside: the counter
 value and its tick/TOP/BOTTOM strobes arrive on sys_clk_i, the capture
 pin and comparator output are asynchronous.
*/
// Implementation choices: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module tcc_capture_compare (
   input  wire  logic                        sys_clk_i,
   input  wire  logic                        reset_i,
   input  wire  logic                        ce_i,
   input  wire  logic [tcc_pkg::ADDR_W-1:0]  s_axi_awaddr_i,
   input  wire  logic                        s_axi_awvalid_i,
   output logic                              s_axi_awready_o,
   input  wire  logic [31:0]                 s_axi_wdata_i,
   input  wire  logic [3:0]                  s_axi_wstrb_i,
   input  wire  logic                        s_axi_wvalid_i,
   output logic                              s_axi_wready_o,
   output logic [1:0]                        s_axi_bresp_o,
   output logic                              s_axi_bvalid_o,
   input  wire  logic                        s_axi_bready_i,
   input  wire  logic [tcc_pkg::ADDR_W-1:0]  s_axi_araddr_i,
   input  wire  logic                        s_axi_arvalid_i,
   output logic                              s_axi_arready_o,
   output logic [31:0]                       s_axi_rdata_o,
   output logic [1:0]                        s_axi_rresp_o,
   output logic                              s_axi_rvalid_o,
   input  wire  logic                        s_axi_rready_i,
   input  wire  logic [15:0]                 counter_value_i,
   input  wire  logic                        timer_tick_i,
   input  wire  logic                        at_top_i,
   input  wire  logic                        at_bottom_i,
   input  wire  logic                        capture_input_pin_i,
   input  wire  logic                        comparator_output_i,
   input  wire  logic                        capture_irq_ack_i,
   input  wire  logic [tcc_pkg::NUM_CH-1:0]  compare_irq_ack_i,
   output logic                              counter_load_o,
   output logic [15:0]                       counter_load_value_o,
   output logic [15:0]                       top_value_o,
   output logic                              capture_irq_o,
   output logic [tcc_pkg::NUM_CH-1:0]        compare_irq_o,
   output logic [tcc_pkg::NUM_CH-1:0]        compare_output_o
);
   import tcc_pkg::*;

   logic [3:0]          waveform_mode_bits;
   logic                noise_filter_enable;
   logic                edge_rising;
   logic                comparator_capture_select;
   logic                capture_irq_enable;
   logic [NUM_CH-1:0]   compare_irq_enable;
   logic [5:0]          output_action_bits;
   logic                capture_flag;
   logic [NUM_CH-1:0]   compare_flag;
   logic [15:0]         capture_register;
   logic [7:0]          temp_high;
   logic [15:0]         compare_value [NUM_CH];
   logic [15:0]         compare_buffer [NUM_CH];
   logic                match_block;

   logic                aw_held;
   logic                w_held;
   logic [7:0]          aw_addr_q;
   logic [7:0]          w_byte_q;
   logic                w_lane0_q;
   logic                do_write;
   logic                wr_en;
   logic                ar_take;
   logic [31:0]         next_rdata;

   logic                pin_s1, pin_s2, cmp_s1, cmp_s2;
   logic                trig_src;
   logic [FILT_LEN-1:0] filt_sh;
   logic                filt_q;
   logic                filt_now;
   logic                edge_in;
   logic                edge_prev;
   logic                capture_event;

   logic                icr_top, pwm_mode, upd_at_top;
   logic                buf_xfer;
   logic [NUM_CH-1:0]   match_evt;
   logic [NUM_CH-1:0]   force_stb;

   function automatic logic mapped(input logic [7:0] a);
      return (a <= OFS_LAST) && (a[1:0] == 2'h0);
   endfunction

   // Mode decode
   always_comb begin
      unique case (waveform_mode_bits)
         4'h8, 4'hA, 4'hC, 4'hE: icr_top = 1'b1;
         default:                icr_top = 1'b0;
      endcase
      unique case (waveform_mode_bits)
         4'h0, 4'h4, 4'hC, 4'hD: pwm_mode = 1'b0;
         default:                pwm_mode = 1'b1;
      endcase
      unique case (waveform_mode_bits)
         4'h1, 4'h2, 4'h3, 4'hA, 4'hB: upd_at_top = 1'b1;
         default:                      upd_at_top = 1'b0;
      endcase
   end

   // AXI write channel: address and data taken in either order
   assign s_axi_awready_o = ce_i & ~aw_held & ~s_axi_bvalid_o;
   assign s_axi_wready_o  = ce_i & ~w_held & ~s_axi_bvalid_o;
   assign do_write        = ce_i & aw_held & w_held & ~s_axi_bvalid_o;
   // Byte registers: a write without lane 0 is answered but ignored
   assign wr_en           = do_write & mapped(aw_addr_q) & w_lane0_q;

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         aw_held   <= 1'b0;
         aw_addr_q <= 8'h00;
      end else if (ce_i) begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_held   <= 1'b1;
            aw_addr_q <= s_axi_awaddr_i;
         end else if (do_write) begin
            aw_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         w_held    <= 1'b0;
         w_byte_q  <= 8'h00;
         w_lane0_q <= 1'b0;
      end else if (ce_i) begin
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_held    <= 1'b1;
            w_byte_q  <= s_axi_wdata_i[7:0];
            w_lane0_q <= s_axi_wstrb_i[0];
         end else if (do_write) begin
            w_held <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_axi_bvalid_o <= 1'b0;
         s_axi_bresp_o  <= RESP_OKAY;
      end else if (ce_i) begin
         if (do_write) begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
         end
      end
   end

   // AXI read channel
   assign s_axi_arready_o = ce_i & ~s_axi_rvalid_o;
   assign ar_take         = s_axi_arvalid_i & s_axi_arready_o;

   always_comb begin
      next_rdata = 32'h0000_0000;
      unique case (s_axi_araddr_i)
         OFS_CTRL:   next_rdata[6:0] = {comparator_capture_select, edge_rising,
                                        noise_filter_enable, waveform_mode_bits};
         OFS_IRQ_EN: next_rdata[3:0] = {compare_irq_enable, capture_irq_enable};
         OFS_FLAGS:  next_rdata[6:0] = {compare_output_o, compare_flag, capture_flag};
         OFS_ACTION: next_rdata[5:0] = output_action_bits;
         OFS_CAP_LO: next_rdata[7:0] = capture_register[7:0];
         OFS_CAP_HI: next_rdata[7:0] = temp_high;
         OFS_CNT_LO: next_rdata[7:0] = counter_value_i[7:0];
         OFS_CNT_HI: next_rdata[7:0] = temp_high;
         default:    next_rdata      = 32'h0000_0000;
      endcase
      for (int ch = 0; ch < NUM_CH; ch++) begin
         // Reads see the register that CPU writes land in
         if (s_axi_araddr_i == 8'(OFS_CMP_LO + CMP_STRIDE * ch))
            next_rdata[7:0] = pwm_mode ? compare_buffer[ch][7:0]
                                       : compare_value[ch][7:0];
         if (s_axi_araddr_i == 8'(OFS_CMP_HI + CMP_STRIDE * ch))
            next_rdata[7:0] = pwm_mode ? compare_buffer[ch][15:8]
                                       : compare_value[ch][15:8];
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_axi_rvalid_o <= 1'b0;
         s_axi_rdata_o  <= 32'h0000_0000;
         s_axi_rresp_o  <= RESP_OKAY;
      end else if (ce_i) begin
         if (ar_take) begin
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= next_rdata;
            s_axi_rresp_o  <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
         end
      end
   end

   // Shared high-byte staging; a high-byte write beats a same-cycle low read
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         temp_high <= 8'h00;
      end else if (ce_i) begin
         if (wr_en && (aw_addr_q == OFS_CAP_HI || aw_addr_q == OFS_CNT_HI
                       || aw_addr_q == OFS_CMP_HI
                       || aw_addr_q == 8'(OFS_CMP_HI + CMP_STRIDE)
                       || aw_addr_q == 8'(OFS_CMP_HI + 2 * CMP_STRIDE)))
            temp_high <= w_byte_q;
         else if (ar_take && s_axi_araddr_i == OFS_CAP_LO)
            temp_high <= capture_register[15:8];
         else if (ar_take && s_axi_araddr_i == OFS_CNT_LO)
            temp_high <= counter_value_i[15:8];
      end
   end

   // Control registers
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         {comparator_capture_select, edge_rising,
          noise_filter_enable, waveform_mode_bits} <= CTRL_RST;
         {compare_irq_enable, capture_irq_enable}  <= IRQ_EN_RST;
         output_action_bits                         <= ACTION_RST;
      end else if (ce_i && wr_en) begin
         if (aw_addr_q == OFS_CTRL) begin
            waveform_mode_bits        <= w_byte_q[CTRL_WGM +: 4];
            noise_filter_enable       <= w_byte_q[CTRL_NF];
            edge_rising               <= w_byte_q[CTRL_RISE];
            comparator_capture_select <= w_byte_q[CTRL_COMPARATOR_CAPTURE_SELECT];
         end
         if (aw_addr_q == OFS_IRQ_EN)
            {compare_irq_enable, capture_irq_enable} <= w_byte_q[3:0];
         if (aw_addr_q == OFS_ACTION)
            output_action_bits <= w_byte_q[5:0];
      end
   end

   // Counter load goes to the external counter as a one-cycle pulse
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         counter_load_o       <= 1'b0;
         counter_load_value_o <= WORD_RST;
      end else if (ce_i) begin
         counter_load_o <= wr_en && aw_addr_q == OFS_CNT_LO;
         if (wr_en && aw_addr_q == OFS_CNT_LO)
            counter_load_value_o <= {temp_high, w_byte_q};
      end
   end

   // Capture path
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         pin_s1 <= 1'b0;
         pin_s2 <= 1'b0;
         cmp_s1 <= 1'b0;
         cmp_s2 <= 1'b0;
      end else if (ce_i) begin
         pin_s1 <= capture_input_pin_i;
         pin_s2 <= pin_s1;
         cmp_s1 <= comparator_output_i;
         cmp_s2 <= cmp_s1;
      end
   end

   // Mux glitch on a source change can look like an edge
   assign trig_src = comparator_capture_select ? cmp_s2 : pin_s2;

   // Filter output is combinational on the full window so it adds four cycles
   always_comb begin
      if (&filt_sh)
         filt_now = 1'b1;
      else if (~|filt_sh)
         filt_now = 1'b0;
      else
         filt_now = filt_q;
   end

   assign edge_in = noise_filter_enable ? filt_now : trig_src;
   // Pin driven by its own port register reaches here like any edge
   assign capture_event = ~icr_top
                        & (edge_rising ? (edge_in & ~edge_prev)
                                       : (~edge_in & edge_prev));

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         filt_sh   <= '0;
         filt_q    <= 1'b0;
         edge_prev <= 1'b0;
      end else if (ce_i && !icr_top) begin
         filt_sh   <= {filt_sh[FILT_LEN-2:0], trig_src};
         filt_q    <= filt_now;
         edge_prev <= edge_in;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         capture_register <= WORD_RST;
      end else if (ce_i) begin
         if (capture_event)
            capture_register <= counter_value_i;
         else if (wr_en && icr_top && aw_addr_q == OFS_CAP_LO)
            capture_register <= {temp_high, w_byte_q};
      end
   end

   // Set wins over a same-cycle clear
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         capture_flag <= 1'b0;
      end else if (ce_i) begin
         if (capture_event)
            capture_flag <= 1'b1;
         else if (capture_irq_ack_i
                  || (wr_en && aw_addr_q == OFS_FLAGS && w_byte_q[FLAG_CAP]))
            capture_flag <= 1'b0;
      end
   end

   assign capture_irq_o = capture_flag & capture_irq_enable;

   // Compare side
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i)
         match_block <= 1'b0;
      else if (ce_i) begin
         if (wr_en && aw_addr_q == OFS_CNT_LO)
            match_block <= 1'b1;
         // Load lands one cycle late, so the block outlives the tick that applies it
         else if (timer_tick_i && !counter_load_o)
            match_block <= 1'b0;
      end
   end

   assign buf_xfer = pwm_mode & timer_tick_i
                   & (upd_at_top ? at_top_i : at_bottom_i);

   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++) begin : g_ch
         logic       wr_lo;
         logic [1:0] act;

         assign wr_lo = wr_en && aw_addr_q == 8'(OFS_CMP_LO + CMP_STRIDE * g);
         assign act   = output_action_bits[2*g +: 2];
         assign match_evt[g] = timer_tick_i & ~match_block
                             & (counter_value_i == compare_value[g]);
         assign force_stb[g] = wr_en && aw_addr_q == OFS_FORCE
                             && w_byte_q[g] && !pwm_mode;

         always_ff @(posedge sys_clk_i or posedge reset_i) begin
            if (reset_i) begin
               compare_buffer[g] <= WORD_RST;
               compare_value[g]  <= WORD_RST;
            end else if (ce_i) begin
               if (wr_lo && pwm_mode)
                  compare_buffer[g] <= {temp_high, w_byte_q};
               if (wr_lo && !pwm_mode)
                  compare_value[g] <= {temp_high, w_byte_q};
               else if (buf_xfer)
                  compare_value[g] <= compare_buffer[g];
            end
         end

         always_ff @(posedge sys_clk_i or posedge reset_i) begin
            if (reset_i) begin
               compare_flag[g] <= 1'b0;
            end else if (ce_i) begin
               if (match_evt[g])
                  compare_flag[g] <= 1'b1;
               else if (compare_irq_ack_i[g] || (wr_en && aw_addr_q == OFS_FLAGS
                                                 && w_byte_q[FLAG_CMP + g]))
                  compare_flag[g] <= 1'b0;
            end
         end

         // PWM shaping lives in the waveform generator, so only non-PWM acts here
         always_ff @(posedge sys_clk_i or posedge reset_i) begin
            if (reset_i) begin
               compare_output_o[g] <= 1'b0;
            end else if (ce_i && !pwm_mode && (match_evt[g] || force_stb[g])) begin
               unique case (act)
                  ACT_NONE:   compare_output_o[g] <= compare_output_o[g];
                  ACT_TOGGLE: compare_output_o[g] <= ~compare_output_o[g];
                  ACT_CLEAR:  compare_output_o[g] <= 1'b0;
                  default:    compare_output_o[g] <= 1'b1;
               endcase
            end
         end

         assign compare_irq_o[g] = compare_flag[g] & compare_irq_enable[g];
      end
   endgenerate

   // TOP selection for the external counter
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         top_value_o <= TOP_MAX;
      end else if (ce_i) begin
         unique case (waveform_mode_bits)
            4'h1, 4'h5:             top_value_o <= TOP_8BIT;
            4'h2, 4'h6:             top_value_o <= TOP_9BIT;
            4'h3, 4'h7:             top_value_o <= TOP_10BIT;
            4'h4, 4'h9, 4'hB, 4'hF: top_value_o <= compare_value[0];
            4'h8, 4'hA, 4'hC, 4'hE: top_value_o <= capture_register;
            default:                top_value_o <= TOP_MAX;
         endcase
      end
   end

endmodule
`default_nettype wire

// ### tcc_capture_compare_properties.sv
/* Port checker for tcc_capture_compare.
   Assumes one clock and the active-high asynchronous reset. */
`timescale 1ns/100ps
`default_nettype none
module tcc_capture_compare_props (
   input wire logic       sys_clk_i,
   input wire logic       reset_i,
   input wire logic       s_axi_awready_o,
   input wire logic       s_axi_bvalid_o,
   input wire logic       s_axi_bready_i,
   input wire logic       s_axi_arvalid_i,
   input wire logic       s_axi_arready_o,
   input wire logic       s_axi_rvalid_o,
   input wire logic       s_axi_rready_i,
   input wire logic       timer_tick_i,
   input wire logic       counter_load_o,
   input wire logic       capture_irq_o,
   input wire logic       capture_irq_ack_i,
   input wire logic [2:0] compare_irq_o,
   input wire logic [2:0] compare_irq_ack_i,
   input wire logic [2:0] compare_output_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   chk_write_resp_end: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
      else $error("write response not retired");
   chk_read_resp_end: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
      else $error("read response not retired");
   chk_read_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read not answered next cycle");
   chk_aw_blocked: assert property (s_axi_bvalid_o |-> !s_axi_awready_o)
      else $error("address taken with response pending");
   chk_load_pulse: assert property (counter_load_o |=> !counter_load_o)
      else $error("counter load longer than one cycle");
   chk_cap_irq_drop: assert property ($fell(capture_irq_o)
      |-> $past(capture_irq_ack_i) || $rose(s_axi_bvalid_o))
      else $error("capture request dropped without cause");
   chk_cmp_irq_drop: assert property ($fell(compare_irq_o[0])
      |-> $past(compare_irq_ack_i[0]) || $rose(s_axi_bvalid_o))
      else $error("compare request dropped without cause");
   chk_output_cause: assert property (!$stable(compare_output_o)
      |-> $past(timer_tick_i) || $rose(s_axi_bvalid_o))
      else $error("compare output changed without cause");
   cover property ($rose(capture_irq_o));
   cover property ($rose(compare_irq_o[0]));
   cover property ($changed(compare_output_o));
endmodule
bind tcc_capture_compare tcc_capture_compare_props u_props (.*);
`default_nettype wire

// ### tcc_timer_model.sv
/* Counter and timer tick source beside the capture/compare unit.
   Assumes the unit's load strobe and value share its clock. */
`timescale 1ns/100ps
`default_nettype none
module tcc_timer_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        run_i,
   input  wire logic        load_i,
   input  wire logic [15:0] load_value_i,
   output logic [15:0]      count_o,
   output logic             tick_o,
   output logic             top_o,
   output logic             bottom_o
);
   // Tick every cycle while running, so stamps stay predictable
   assign tick_o   = run_i;
   assign top_o    = count_o == 16'hFFFF;
   assign bottom_o = count_o == 16'h0000;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         count_o <= 16'h0000;
      end else if (load_i) begin
         count_o <= load_value_i;
      end else if (run_i) begin
         count_o <= count_o + 16'h0001;
      end
   end
endmodule
`default_nettype wire

// ### test_tcc_capture_compare.sv
/* Self-checking bench for tcc_capture_compare.
   Assumes tcc_timer_model as counter and an AXI4-Lite master here. */
`timescale 1ns/100ps
`default_nettype none
module test_tcc_capture_compare;
   import tcc_pkg::*;
   logic sys_clk_i, reset_i, ce_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i;
   logic [7:0] s_axi_awaddr_i, s_axi_araddr_i, rdat;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o;
   logic [3:0] s_axi_wstrb_i;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o, run;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, resp;
   logic [15:0] counter_value_i, counter_load_value_o, top_value_o;
   logic timer_tick_i, at_top_i, at_bottom_i, capture_input_pin_i, comparator_output_i;
   logic capture_irq_ack_i, counter_load_o, capture_irq_o;
   logic [2:0] compare_irq_ack_i, compare_irq_o, compare_output_o;
   int fail_count, checks_done;
   tcc_capture_compare DUT (.*);
   tcc_timer_model u_tmr (.clk_i(sys_clk_i), .rst_i(reset_i), .run_i(run), .load_i(counter_load_o),
      .load_value_i(counter_load_value_o), .count_o(counter_value_i), .tick_o(timer_tick_i),
      .top_o(at_top_i), .bottom_o(at_bottom_i));
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      checks_done++;
      if (g !== e) begin
         fail_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk_i);
      s_axi_awaddr_i  <= a;
      s_axi_wdata_i   <= {24'h000000, d};
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i  <= 1'b1;
      s_axi_bready_i  <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
      end while (s_axi_bvalid_o !== 1'b1);
      s_axi_bready_i <= 1'b0;
      resp = s_axi_bresp_o;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk_i);
      s_axi_araddr_i  <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i  <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
      end while (s_axi_rvalid_o !== 1'b1);
      s_axi_rready_i <= 1'b0;
      rdat = s_axi_rdata_o[7:0];
      resp = s_axi_rresp_o;
   endtask
   task automatic cap(input logic [15:0] e);
      logic [7:0] lo;
      rd(OFS_CAP_LO);
      lo = rdat;
      rd(OFS_CAP_HI);
      chk("capture_register", e, {rdat, lo});
   endtask
   task automatic pins(input logic v);
      capture_input_pin_i <= v;
      repeat (10) @(posedge sys_clk_i);
   endtask
   task automatic t_capture;
      wr(OFS_CNT_HI, 8'h12);
      wr(OFS_CNT_LO, 8'h34);
      wr(OFS_IRQ_EN, 8'h01);
      wr(OFS_CTRL, 8'h20);
      wr(OFS_CAP_HI, 8'hAB);
      wr(OFS_CAP_LO, 8'hCD);
      cap(16'h0000);
      pins(1'b1);
      chk("capture_irq", 16'h0001, capture_irq_o);
      cap(16'h1234);
      rd(OFS_FLAGS);
      chk("capture_flag", 16'h0001, rdat & 8'h01);
      capture_irq_ack_i <= 1'b1;
      @(posedge sys_clk_i);
      capture_irq_ack_i <= 1'b0;
      @(posedge sys_clk_i);
      chk("capture_irq_ack", 16'h0000, capture_irq_o);
      wr(OFS_CNT_HI, 8'h00);
      wr(OFS_CNT_LO, 8'h56);
      pins(1'b0);
      pins(1'b1);
      wr(OFS_FLAGS, 8'h01);
      chk("capture_irq_w1c", 16'h0000, capture_irq_o);
      cap(16'h0056);
   endtask
   task automatic lat(input logic [7:0] c, output int n);
      wr(OFS_CTRL, c);
      pins(1'b0);
      wr(OFS_FLAGS, 8'h01);
      capture_input_pin_i <= 1'b1;
      n = 0;
      while (capture_irq_o !== 1'b1 && n < 40) begin
         @(posedge sys_clk_i);
         n++;
      end
   endtask
   task automatic t_filter;
      int a;
      int b;
      lat(8'h20, a);
      lat(8'h30, b);
      chk("filter_delay", 16'h0004, 16'(b - a));
   endtask
   task automatic t_source;
      wr(OFS_CTRL, 8'h60);
      wr(OFS_FLAGS, 8'h01);
      comparator_output_i <= 1'b1;
      repeat (5) @(posedge sys_clk_i);
      rd(OFS_FLAGS);
      chk("comparator_capture", 16'h0001, rdat & 8'h01);
   endtask
   task automatic t_force;
      wr(OFS_ACTION, 8'h01);
      wr(OFS_FLAGS, 8'h0F);
      wr(OFS_FORCE, 8'h01);
      chk("forced_output", 16'h0001, compare_output_o);
      rd(OFS_FLAGS);
      chk("flags_after_force", 16'h0010, rdat);
   endtask
   task automatic t_compare;
      wr(OFS_CMP_HI, 8'h00);
      wr(OFS_CMP_LO, 8'h60);
      wr(OFS_IRQ_EN, 8'h02);
      run <= 1'b1;
      repeat (20) @(posedge sys_clk_i);
      run <= 1'b0;
      chk("compare_irq", 16'h0001, compare_irq_o);
      chk("match_output", 16'h0000, compare_output_o);
      wr(OFS_FLAGS, 8'h02);
      chk("compare_irq_w1c", 16'h0000, compare_irq_o);
      run <= 1'b1;
      wr(OFS_CNT_HI, 8'h00);
      wr(OFS_CNT_LO, 8'h60);
      repeat (2) @(posedge sys_clk_i);
      run <= 1'b0;
      chk("blocked_match", 16'h0000, compare_irq_o);
      chk("blocked_output", 16'h0000, compare_output_o);
      wr(8'(OFS_CMP_HI + CMP_STRIDE), 8'h7E);
      wr(8'(OFS_CMP_LO + CMP_STRIDE), 8'h11);
      wr(OFS_CNT_HI, 8'h00);
      rd(8'(OFS_CMP_HI + CMP_STRIDE));
      chk("compare_b_high", 16'h007E, rdat);
      wr(OFS_CTRL, 8'h04);
      @(posedge sys_clk_i);
      chk("top_value", 16'h0060, top_value_o);
   endtask
   task automatic t_unmapped;
      wr(8'h3C, 8'h55);
      chk("write_resp", RESP_SLVERR, resp);
      rd(8'h40);
      chk("read_resp", RESP_SLVERR, resp);
      chk("read_data", 16'h0000, rdat);
   endtask
   task automatic test_done;
      if (fail_count == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      sys_clk_i = 1'b0;
      forever #5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      repeat (20000) @(posedge sys_clk_i);
      fail_count++;
      test_done;
   end
   initial begin
      {reset_i, ce_i, s_axi_wstrb_i, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = {1'b1, 1'b1, 4'hF, 48'h0};
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = 5'h00;
      {run, capture_input_pin_i, comparator_output_i, capture_irq_ack_i, compare_irq_ack_i} = 7'h00;
      repeat (12) @(posedge sys_clk_i);
      reset_i <= 1'b0;
      t_capture;
      t_filter;
      t_source;
      t_force;
      t_compare;
      t_unmapped;
      test_done;
   end
endmodule
`default_nettype wire
